// >>> rcsc_consts.vh
// constants for the reset and clock source controller
`ifndef RCSC_CONSTS_VH
`define RCSC_CONSTS_VH

// register offsets (byte addresses)
`define RCSC_OFS_BOR_CTL 8'h00
`define RCSC_OFS_CAUSE 8'h04
`define RCSC_OFS_REG_CTL 8'h08
`define RCSC_OFS_RUN_CLK 8'h0C
`define RCSC_OFS_SRST0 8'h10
`define RCSC_OFS_SRST1 8'h14
`define RCSC_OFS_SRST2 8'h18
`define RCSC_OFS_CORE_RST 8'h1C
`define RCSC_OFS_WD_LOAD 8'h20
`define RCSC_OFS_WD_VALUE 8'h24
`define RCSC_OFS_WD_CTL 8'h28
`define RCSC_OFS_WD_STAT 8'h2C
`define RCSC_OFS_BOR_STAT 8'h30

// power and brown-out control fields
`define RCSC_BOR_INT_EN_BIT 0
`define RCSC_BOR_RST_EN_BIT 1

// reset cause fields
`define RCSC_CAUSE_EXT_BIT 0
`define RCSC_CAUSE_BOR_BIT 1
`define RCSC_CAUSE_WDT_BIT 2
`define RCSC_CAUSE_SW_BIT 3
`define RCSC_CAUSE_RST 4'h1

// core reset control field
`define RCSC_SYSREQ_BIT 2

// run clock configuration fields
`define RCSC_MAIN_OSC_DIS_BIT 0
`define RCSC_OSC_SOURCE_SELECT_LSB 4
`define RCSC_BYPASS_BIT 11
`define RCSC_DS_LF_BIT 27
`define RCSC_OSC_SOURCE_SELECT_EXT_LSB 28
`define RCSC_USE_EXT_BIT 31
`define RCSC_RUN_CLK_RST 32'h00000811

// system clock source codes
`define RCSC_SRC_MAIN 3'h0
`define RCSC_SRC_INT 3'h1
`define RCSC_SRC_INT_DIV4 3'h2
`define RCSC_SRC_LF30K 3'h3
`define RCSC_SRC_PLL 3'h4
`define RCSC_SRC_RTC 3'h7

// regulator adjust: signed steps around nominal, +-5 spans 2.25 V to 2.75 V
`define RCSC_REGULATOR_VOLTAGE_ADJUST_MAX 6'h05
`define RCSC_REGULATOR_VOLTAGE_ADJUST_MIN 6'h3B
`define RCSC_REGULATOR_VOLTAGE_ADJUST_RST 6'h00

// watchdog fields and reset values
`define RCSC_WD_INT_EN_BIT 0
`define RCSC_WD_RST_EN_BIT 1
`define RCSC_WD_LOAD_RST 32'hFFFFFFFF

// length of an internal reset pulse in clock cycles
`define RCSC_RST_PULSE_CYC 8'h10

`endif

// >>> rcsc_ctrl.v
// reset sequencing, reset cause, watchdog, regulator trim and clock source select
//
// The placing of the registers and strobed register access were decided locally.
`include "rcsc_consts.vh"

// Summary of operation
// - brown-out does nothing after reset until software enables it.
// - a brown-out raises either an interrupt or a system reset.
// - brown-out resets only while the brown-out reset enable bit is set.
// - brown-out reset holds internal reset until supply is good again.
// - after a brown-out reset the cause register shows a brown-out bit.
// - a peripheral is reset when its bit is written one then zero.
// - soft reset bit positions match the peripheral clock gating positions.
// - a peripheral soft reset reaches every clock domain of that unit.
// - the system reset request bit pulses the whole-system internal reset.
// - watchdog interrupts on first timeout, requests reset on the second.
// - on first timeout the watchdog counter reloads and keeps counting.
// - watchdog resets only on zero with interrupt pending and reset enabled.
// - regulator adjust field trims core supply between 2.25 V and 2.75 V.
// - system clock is the internal oscillator from reset until changed.
// - the clock mux also offers the PLL and internal oscillator divided by four.
// - only the main oscillator, code 0x0 with bypass clear, feeds the PLL.
// - with bypass set, source code 0..3 picks main, internal, internal/4, 30 kHz.
// - with bypass set, extended source 0x7 picks the real-time oscillator.
// - the 30 kHz oscillator clocks deep-sleep so the main oscillator can stop.
// - cause bits persist; pin or power-on reset leaves only its own bit.
module rcsc_ctrl (
    input wire sys_clk,
    input wire reset_n,
    input wire brownout_detect,
    input wire deep_sleep,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    output reg int_reset_q,
    output reg brownout_irq_q,
    output reg watchdog_irq_q,
    output reg [31:0] periph_rst0_q,
    output reg [31:0] periph_rst1_q,
    output reg [31:0] periph_rst2_q,
    output reg [2:0] system_clock_sel_q,
    output reg main_osc_enable_q,
    output reg [5:0] regulator_voltage_adjust_q
);

    localparam ST_IDLE = 2'b00;
    localparam ST_PULSE = 2'b01;
    localparam ST_BOR = 2'b10;

    // brown-out detector is analog and asynchronous
    reg bod_s1_q;
    reg bod_s2_q;
    reg bod_s3_q;
    reg bod_q;
    reg bod_prev_q;

    reg [1:0] power_brownout_control_reg;
    reg bor_stat_q;
    reg [3:0] reset_cause_reg;
    reg [31:0] run_clock_config_reg;
    reg [1:0] wd_ctl_q;
    reg [31:0] watchdog_load_value;
    reg [31:0] wd_cnt_q;
    reg wd_stat_q;
    reg wd_rst_req_q;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [7:0] pulse_cnt_q;
    reg [7:0] pulse_cnt_d;
    reg [31:0] rd_d;
    reg [2:0] clk_sel_d;

    // writes are refused for the whole reset pulse; reads still answer
    wire wr_ok = reg_wr & ~int_reset_q;
    wire wr_bor_ctl = wr_ok & (reg_addr == `RCSC_OFS_BOR_CTL);
    wire wr_cause = wr_ok & (reg_addr == `RCSC_OFS_CAUSE);
    wire wr_reg_ctl = wr_ok & (reg_addr == `RCSC_OFS_REG_CTL);
    wire wr_run_clk = wr_ok & (reg_addr == `RCSC_OFS_RUN_CLK);
    wire wr_srst0 = wr_ok & (reg_addr == `RCSC_OFS_SRST0);
    wire wr_srst1 = wr_ok & (reg_addr == `RCSC_OFS_SRST1);
    wire wr_srst2 = wr_ok & (reg_addr == `RCSC_OFS_SRST2);
    wire wr_core = wr_ok & (reg_addr == `RCSC_OFS_CORE_RST);
    wire wr_wd_load = wr_ok & (reg_addr == `RCSC_OFS_WD_LOAD);
    wire wr_wd_ctl = wr_ok & (reg_addr == `RCSC_OFS_WD_CTL);
    wire wr_wd_stat = wr_ok & (reg_addr == `RCSC_OFS_WD_STAT);
    wire wr_bor_stat = wr_ok & (reg_addr == `RCSC_OFS_BOR_STAT);

    wire bor_int_en = power_brownout_control_reg[`RCSC_BOR_INT_EN_BIT];
    wire brownout_reset_enable = power_brownout_control_reg[`RCSC_BOR_RST_EN_BIT];
    wire bod_rise = bod_q & ~bod_prev_q;
    wire bor_trip = bod_q & brownout_reset_enable;
    // with reset enabled the event goes to the sequencer instead of the interrupt
    wire bor_int_set = bod_rise & bor_int_en & ~brownout_reset_enable;
    wire system_reset_request_bit = wr_core & reg_wdata[`RCSC_SYSREQ_BIT];

    wire wd_int_en = wd_ctl_q[`RCSC_WD_INT_EN_BIT];
    wire wd_rst_en = wd_ctl_q[`RCSC_WD_RST_EN_BIT];
    // the counter runs, and can time out, only while the watchdog is enabled
    wire wd_zero = wd_int_en & (wd_cnt_q == 32'h00000000);
    wire wd_first = wd_zero & ~wd_stat_q;
    wire wd_second = wd_zero & wd_stat_q & wd_rst_en;

    // two's complement steps around the nominal core supply
    wire [5:0] regulator_voltage_adjust_in = reg_wdata[5:0];
    wire regulator_voltage_adjust_neg = regulator_voltage_adjust_in[5];

    wire bypass = run_clock_config_reg[`RCSC_BYPASS_BIT];
    wire [1:0] osc_source_select = run_clock_config_reg[`RCSC_OSC_SOURCE_SELECT_LSB+1:`RCSC_OSC_SOURCE_SELECT_LSB];
    wire [2:0] osc_source_select_ext =
        run_clock_config_reg[`RCSC_OSC_SOURCE_SELECT_EXT_LSB+2:`RCSC_OSC_SOURCE_SELECT_EXT_LSB];
    wire use_ext = run_clock_config_reg[`RCSC_USE_EXT_BIT];
    wire ds_low_freq = run_clock_config_reg[`RCSC_DS_LF_BIT];
    wire main_osc_disable = run_clock_config_reg[`RCSC_MAIN_OSC_DIS_BIT];
    wire in_deep_lf = deep_sleep & ds_low_freq;

    // input synchroniser: a change counts once stages two and three agree
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bod_s1_q <= 1'b0;
            bod_s2_q <= 1'b0;
            bod_s3_q <= 1'b0;
            bod_q <= 1'b0;
            // history starts at the idle level, so no false edge follows reset
            bod_prev_q <= 1'b0;
        end else begin
            bod_s1_q <= brownout_detect;
            bod_s2_q <= bod_s1_q;
            bod_s3_q <= bod_s2_q;
            if (bod_s2_q == bod_s3_q) begin
                bod_q <= bod_s3_q;
            end
            bod_prev_q <= bod_q;
        end
    end

    // reset sequencer
    always @* begin
        st_d = st_q;
        pulse_cnt_d = pulse_cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (bor_trip) begin
                    st_d = ST_BOR;
                end else if (wd_rst_req_q | system_reset_request_bit) begin
                    st_d = ST_PULSE;
                    pulse_cnt_d = `RCSC_RST_PULSE_CYC;
                end
            end
            ST_BOR: begin
                // held like the reset pin until the supply recovers
                if (!bod_q) begin
                    st_d = ST_PULSE;
                    pulse_cnt_d = `RCSC_RST_PULSE_CYC;
                end
            end
            // fixed length, so every reset source gives the same minimum pulse
            ST_PULSE: begin
                if (pulse_cnt_q == 8'h01) begin
                    st_d = ST_IDLE;
                end
                pulse_cnt_d = pulse_cnt_q - 8'h01;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            pulse_cnt_q <= 8'h00;
            int_reset_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pulse_cnt_q <= pulse_cnt_d;
            int_reset_q <= (st_d != ST_IDLE);
        end
    end

    // cause bits survive the internal reset; only the pin/power reset or a software write clears them
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_cause_reg <= `RCSC_CAUSE_RST;
        end else begin
            if (wr_cause) begin
                reset_cause_reg <= reg_wdata[3:0];
            end
            // set wins over a clearing write in the same cycle
            if (st_q == ST_IDLE && bor_trip) begin
                reset_cause_reg[`RCSC_CAUSE_BOR_BIT] <= 1'b1;
            end else if (st_q == ST_IDLE && wd_rst_req_q) begin
                reset_cause_reg[`RCSC_CAUSE_WDT_BIT] <= 1'b1;
            end else if (st_q == ST_IDLE && system_reset_request_bit) begin
                reset_cause_reg[`RCSC_CAUSE_SW_BIT] <= 1'b1;
            end
        end
    end

    // brown-out control and interrupt status
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_brownout_control_reg <= 2'b00;
            bor_stat_q <= 1'b0;
            brownout_irq_q <= 1'b0;
        end else if (int_reset_q) begin
            power_brownout_control_reg <= 2'b00;
            bor_stat_q <= 1'b0;
            brownout_irq_q <= 1'b0;
        end else begin
            if (wr_bor_ctl) begin
                power_brownout_control_reg <= reg_wdata[1:0];
            end
            if (bor_int_set) begin
                bor_stat_q <= 1'b1;
            end else if (wr_bor_stat && reg_wdata[0]) begin
                bor_stat_q <= 1'b0;
            end
            brownout_irq_q <= bor_int_set | (bor_stat_q & ~(wr_bor_stat & reg_wdata[0]));
        end
    end

    // peripheral soft resets: the line is held while the bit is one
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            periph_rst0_q <= 32'h00000000;
            periph_rst1_q <= 32'h00000000;
            periph_rst2_q <= 32'h00000000;
        end else if (int_reset_q) begin
            periph_rst0_q <= 32'h00000000;
            periph_rst1_q <= 32'h00000000;
            periph_rst2_q <= 32'h00000000;
        end else begin
            // same bit layout as clock gating; one line per unit fans to all its domains
            if (wr_srst0) begin
                periph_rst0_q <= reg_wdata;
            end
            if (wr_srst1) begin
                periph_rst1_q <= reg_wdata;
            end
            if (wr_srst2) begin
                periph_rst2_q <= reg_wdata;
            end
        end
    end

    // watchdog: first zero interrupts and reloads, second zero requests reset
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_ctl_q <= 2'b00;
            watchdog_load_value <= `RCSC_WD_LOAD_RST;
            wd_cnt_q <= `RCSC_WD_LOAD_RST;
            wd_stat_q <= 1'b0;
            wd_rst_req_q <= 1'b0;
            watchdog_irq_q <= 1'b0;
        end else if (int_reset_q) begin
            wd_ctl_q <= 2'b00;
            watchdog_load_value <= `RCSC_WD_LOAD_RST;
            wd_cnt_q <= `RCSC_WD_LOAD_RST;
            wd_stat_q <= 1'b0;
            wd_rst_req_q <= 1'b0;
            watchdog_irq_q <= 1'b0;
        end else begin
            if (wr_wd_ctl) begin
                // reset enable cannot be taken back once set, only by a reset
                wd_ctl_q <= reg_wdata[1:0] | {wd_rst_en, 1'b0};
            end
            if (wr_wd_load) begin
                watchdog_load_value <= reg_wdata;
                wd_cnt_q <= reg_wdata;
            end else if (wd_zero) begin
                wd_cnt_q <= watchdog_load_value;
            end else if (wd_int_en) begin
                wd_cnt_q <= wd_cnt_q - 32'h00000001;
            end
            if (wd_first) begin
                wd_stat_q <= 1'b1;
            end else if (wr_wd_stat) begin
                wd_stat_q <= 1'b0;
            end
            wd_rst_req_q <= wd_second;
            watchdog_irq_q <= wd_first | (wd_stat_q & ~wr_wd_stat);
        end
    end

    // regulator trim, clamped to the legal window
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regulator_voltage_adjust_q <= `RCSC_REGULATOR_VOLTAGE_ADJUST_RST;
        end else if (int_reset_q) begin
            regulator_voltage_adjust_q <= `RCSC_REGULATOR_VOLTAGE_ADJUST_RST;
        end else if (wr_reg_ctl) begin
            if (!regulator_voltage_adjust_neg && regulator_voltage_adjust_in > `RCSC_REGULATOR_VOLTAGE_ADJUST_MAX) begin
                regulator_voltage_adjust_q <= `RCSC_REGULATOR_VOLTAGE_ADJUST_MAX;
            end else if (regulator_voltage_adjust_neg && regulator_voltage_adjust_in < `RCSC_REGULATOR_VOLTAGE_ADJUST_MIN) begin
                regulator_voltage_adjust_q <= `RCSC_REGULATOR_VOLTAGE_ADJUST_MIN;
            end else begin
                regulator_voltage_adjust_q <= regulator_voltage_adjust_in;
            end
        end
    end

    // clock source selection
    always @* begin
        if (in_deep_lf) begin
            clk_sel_d = `RCSC_SRC_LF30K;
        end else if (!bypass) begin
            // without a main oscillator reference the PLL would not lock
            if (osc_source_select == 2'b00) begin
                clk_sel_d = `RCSC_SRC_PLL;
            end else begin
                clk_sel_d = `RCSC_SRC_INT;
            end
        end else if (use_ext && osc_source_select_ext == `RCSC_SRC_RTC) begin
            clk_sel_d = `RCSC_SRC_RTC;
        end else begin
            clk_sel_d = {1'b0, osc_source_select};
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_clock_config_reg <= `RCSC_RUN_CLK_RST;
            system_clock_sel_q <= `RCSC_SRC_INT;
            main_osc_enable_q <= 1'b0;
        end else if (int_reset_q) begin
            run_clock_config_reg <= `RCSC_RUN_CLK_RST;
            system_clock_sel_q <= `RCSC_SRC_INT;
            main_osc_enable_q <= 1'b0;
        end else begin
            if (wr_run_clk) begin
                run_clock_config_reg <= reg_wdata;
            end
            system_clock_sel_q <= clk_sel_d;
            // stopped in low-frequency deep sleep; software must let it settle after wake
            main_osc_enable_q <= ~main_osc_disable & ~in_deep_lf;
        end
    end

    // register read path, data valid the cycle after the strobe
    always @* begin
        case (reg_addr)
            `RCSC_OFS_BOR_CTL: rd_d = {30'h00000000, power_brownout_control_reg};
            `RCSC_OFS_CAUSE: rd_d = {28'h0000000, reset_cause_reg};
            `RCSC_OFS_REG_CTL: rd_d = {26'h0000000, regulator_voltage_adjust_q};
            `RCSC_OFS_RUN_CLK: rd_d = run_clock_config_reg;
            `RCSC_OFS_SRST0: rd_d = periph_rst0_q;
            `RCSC_OFS_SRST1: rd_d = periph_rst1_q;
            `RCSC_OFS_SRST2: rd_d = periph_rst2_q;
            `RCSC_OFS_WD_LOAD: rd_d = watchdog_load_value;
            `RCSC_OFS_WD_VALUE: rd_d = wd_cnt_q;
            `RCSC_OFS_WD_CTL: rd_d = {30'h00000000, wd_ctl_q};
            `RCSC_OFS_WD_STAT: rd_d = {31'h00000000, wd_stat_q};
            `RCSC_OFS_BOR_STAT: rd_d = {30'h00000000, bod_q, bor_stat_q};
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end else begin
            // zero outside the answer cycle, so stale data is never taken for new
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule

// >>> rcsc_monitor.sv
// port-level checker for the reset and clock source controller
`include "rcsc_consts.vh"
module rcsc_monitor (
    input wire sys_clk,
    input wire reset_n,
    input wire brownout_detect,
    input wire deep_sleep,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire int_reset_q,
    input wire brownout_irq_q,
    input wire watchdog_irq_q,
    input wire [31:0] periph_rst0_q,
    input wire [31:0] periph_rst1_q,
    input wire [31:0] periph_rst2_q,
    input wire [2:0] system_clock_sel_q,
    input wire main_osc_enable_q,
    input wire [5:0] regulator_voltage_adjust_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // length of the current internal reset pulse, saturating
    reg [7:0] hi_cnt_q;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) hi_cnt_q <= 8'h00;
        else if (!int_reset_q) hi_cnt_q <= 8'h00;
        else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
    end
    wire wr_ok = reg_wr && !int_reset_q;
    sw_req_reset_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_CORE_RST && reg_wdata[`RCSC_SYSREQ_BIT]
        |=> int_reset_q) else $error("system reset request gave no reset");
    pulse_length_a:
    assert property ($fell(int_reset_q) |-> hi_cnt_q >= `RCSC_RST_PULSE_CYC)
        else $error("internal reset pulse too short");
    reset_clears_a:
    assert property (int_reset_q [*3] |-> !watchdog_irq_q && !brownout_irq_q
        && system_clock_sel_q == `RCSC_SRC_INT && regulator_voltage_adjust_q == 6'h00
        && periph_rst0_q == 32'h00000000) else $error("internal reset left state behind");
    reset_wr_ignored_a:
    assert property (int_reset_q && $past(int_reset_q) && reg_wr
        && reg_addr == `RCSC_OFS_REG_CTL |=> $stable(regulator_voltage_adjust_q))
        else $error("write taken during internal reset");
    trim_range_a:
    assert property ($signed(regulator_voltage_adjust_q) <= 6'sh05
        && $signed(regulator_voltage_adjust_q) >= -6'sh05) else $error("trim out of range");
    trim_write_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_REG_CTL && reg_wdata[31:6] == 26'h0
        && $signed(reg_wdata[5:0]) <= 6'sh05 && $signed(reg_wdata[5:0]) >= -6'sh05
        |=> regulator_voltage_adjust_q == $past(reg_wdata[5:0])) else $error("trim not stored");
    soft_rst_mirror_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_SRST0
        |=> periph_rst0_q == $past(reg_wdata)) else $error("soft reset bits not applied");
    osc_enable_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_RUN_CLK && !reg_wdata[`RCSC_MAIN_OSC_DIS_BIT]
        |-> ##[1:2] main_osc_enable_q) else $error("main oscillator not enabled");
    pll_select_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_RUN_CLK && reg_wdata == 32'h00000000
        && !deep_sleep |-> ##[1:2] system_clock_sel_q == `RCSC_SRC_PLL)
        else $error("pll not selected");
    rtc_select_a:
    assert property (wr_ok && reg_addr == `RCSC_OFS_RUN_CLK && reg_wdata == 32'hF0000800
        && !deep_sleep |-> ##[1:2] system_clock_sel_q == `RCSC_SRC_RTC)
        else $error("real-time oscillator not selected");
    clock_code_a:
    assert property (system_clock_sel_q != 3'h5 && system_clock_sel_q != 3'h6)
        else $error("undefined clock source code");
endmodule

// >>> test_reset_and_clock_source_control.sv
// self-checking bench for the reset and clock source controller
`include "rcsc_consts.vh"
module test_reset_and_clock_source_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic brownout_detect = 1'b0;
    logic deep_sleep = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [31:0] reg_rdata_q, periph_rst0_q, periph_rst1_q, periph_rst2_q;
    wire int_reset_q, brownout_irq_q, watchdog_irq_q, main_osc_enable_q;
    wire [2:0] system_clock_sel_q;
    wire [5:0] regulator_voltage_adjust_q;
    int n_fail = 0;
    int cmp_count = 0;
    int i;
    logic [31:0] clk_cfg [0:6] = '{32'h800, 32'h810, 32'h820, 32'h830, 32'h0, 32'h10,
        32'hF0000800};
    logic [2:0] clk_exp [0:6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h7};
    logic [5:0] trim_in [0:4] = '{6'h05, 6'h07, 6'h3B, 6'h39, 6'h02};
    logic [5:0] trim_exp [0:4] = '{6'h05, 6'h05, 6'h3B, 6'h3B, 6'h02};
    always #5 sys_clk = ~sys_clk;
    rcsc_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .brownout_detect(brownout_detect),
        .deep_sleep(deep_sleep), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .int_reset_q(int_reset_q), .brownout_irq_q(brownout_irq_q),
        .watchdog_irq_q(watchdog_irq_q), .periph_rst0_q(periph_rst0_q),
        .periph_rst1_q(periph_rst1_q), .periph_rst2_q(periph_rst2_q),
        .system_clock_sel_q(system_clock_sel_q), .main_osc_enable_q(main_osc_enable_q),
        .regulator_voltage_adjust_q(regulator_voltage_adjust_q));
    task complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk_pin(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle cycle after each strobe so no strobe is driven twice in a time step
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // read data looked at just after the edge that launches it, while it stands
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk_pin(reg_rdata_q, exp);
    endtask
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function logic pick(input int s);
        return s == 0 ? int_reset_q : (s == 1 ? watchdog_irq_q : brownout_irq_q);
    endfunction
    task wait_on(input int s, input logic lvl, input int lim);
        int k;
        k = 0;
        while (pick(s) !== lvl && k < lim) begin
            step(1);
            k++;
        end
        if (pick(s) !== lvl) begin
            n_fail++;
            $display("Error at %0t: wait ran out, got %h expected %h", $time, pick(s), lvl);
            complete_run;
        end
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        step(2);
        chk_pin(32'(system_clock_sel_q), 32'h1);
        chk_pin(32'(main_osc_enable_q), 32'h0);
        rd_chk(`RCSC_OFS_CAUSE, 32'h1);
        rd_chk(`RCSC_OFS_RUN_CLK, `RCSC_RUN_CLK_RST);
        rd_chk(`RCSC_OFS_BOR_CTL, 32'h0);
        rd_chk(`RCSC_OFS_WD_LOAD, `RCSC_WD_LOAD_RST);
        rd_chk(8'h40, 32'h0);
        bus_wr(`RCSC_OFS_RUN_CLK, 32'h00000810);
        step(2);
        chk_pin(32'(main_osc_enable_q), 32'h1);
        chk_pin(32'(system_clock_sel_q), 32'h1);
        for (i = 0; i < 7; i++) begin
            bus_wr(`RCSC_OFS_RUN_CLK, clk_cfg[i]);
            step(2);
            chk_pin(32'(system_clock_sel_q), 32'(clk_exp[i]));
        end
        bus_wr(`RCSC_OFS_RUN_CLK, 32'h08000811);
        deep_sleep <= 1'b1;
        step(2);
        chk_pin(32'(system_clock_sel_q), 32'h3);
        chk_pin(32'(main_osc_enable_q), 32'h0);
        deep_sleep <= 1'b0;
        step(2);
        chk_pin(32'(system_clock_sel_q), 32'h1);
        for (i = 0; i < 5; i++) begin
            bus_wr(`RCSC_OFS_REG_CTL, 32'(trim_in[i]));
            step(1);
            chk_pin(32'(regulator_voltage_adjust_q), 32'(trim_exp[i]));
        end
        for (i = 0; i < 3; i++) begin
            bus_wr(8'h10 + 8'(i * 4), 32'h1 << (i * 9 + 4));
            step(1);
            chk_pin(i == 0 ? periph_rst0_q : i == 1 ? periph_rst1_q : periph_rst2_q,
                32'h1 << (i * 9 + 4));
            bus_wr(8'h10 + 8'(i * 4), 32'h0);
            step(1);
            chk_pin(i == 0 ? periph_rst0_q : i == 1 ? periph_rst1_q : periph_rst2_q,
                32'h0);
        end
        // detector seen while both enables are still off
        brownout_detect <= 1'b1;
        step(10);
        chk_pin({31'h0, brownout_irq_q | int_reset_q}, 32'h0);
        brownout_detect <= 1'b0;
        step(6);
        bus_wr(`RCSC_OFS_BOR_CTL, 32'h1);
        brownout_detect <= 1'b1;
        wait_on(2, 1'b1, 10);
        chk_pin(32'(int_reset_q), 32'h0);
        rd_chk(`RCSC_OFS_BOR_STAT, 32'h3);
        brownout_detect <= 1'b0;
        step(6);
        bus_wr(`RCSC_OFS_BOR_STAT, 32'h1);
        step(2);
        chk_pin(32'(brownout_irq_q), 32'h0);
        bus_wr(`RCSC_OFS_CORE_RST, 32'h4);
        chk_pin(32'(int_reset_q), 32'h1);
        bus_wr(`RCSC_OFS_REG_CTL, 32'h3);
        // a clearing write to the causes is refused while reset is held
        bus_wr(`RCSC_OFS_CAUSE, 32'h0);
        rd_chk(`RCSC_OFS_CAUSE, 32'h9);
        wait_on(0, 1'b0, 20);
        step(1);
        rd_chk(`RCSC_OFS_REG_CTL, 32'h0);
        rd_chk(`RCSC_OFS_RUN_CLK, `RCSC_RUN_CLK_RST);
        bus_wr(`RCSC_OFS_CAUSE, 32'h0);
        bus_wr(`RCSC_OFS_BOR_CTL, 32'h2);
        brownout_detect <= 1'b1;
        wait_on(0, 1'b1, 10);
        step(40);
        chk_pin(32'(int_reset_q), 32'h1);
        brownout_detect <= 1'b0;
        step(8);
        chk_pin(32'(int_reset_q), 32'h1);
        wait_on(0, 1'b0, 40);
        rd_chk(`RCSC_OFS_CAUSE, 32'h2);
        bus_wr(`RCSC_OFS_WD_LOAD, 32'h14);
        bus_wr(`RCSC_OFS_WD_CTL, 32'h3);
        wait_on(1, 1'b1, 60);
        chk_pin(32'(int_reset_q), 32'h0);
        bus_wr(`RCSC_OFS_WD_STAT, 32'h0);
        wait_on(1, 1'b0, 4);
        wait_on(1, 1'b1, 60);
        chk_pin(32'(int_reset_q), 32'h0);
        wait_on(0, 1'b1, 60);
        wait_on(0, 1'b0, 30);
        rd_chk(`RCSC_OFS_CAUSE, 32'h6);
        // pin reset in mid-run wipes the accumulated causes
        reset_n <= 1'b0;
        step(3);
        reset_n <= 1'b1;
        step(2);
        rd_chk(`RCSC_OFS_CAUSE, 32'h1);
        chk_pin(32'(system_clock_sel_q), 32'h1);
        complete_run;
    end
endmodule
bind rcsc_ctrl rcsc_monitor mon (.sys_clk(sys_clk), .reset_n(reset_n),
    .brownout_detect(brownout_detect), .deep_sleep(deep_sleep), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .int_reset_q(int_reset_q), .brownout_irq_q(brownout_irq_q),
    .watchdog_irq_q(watchdog_irq_q), .periph_rst0_q(periph_rst0_q),
    .periph_rst1_q(periph_rst1_q), .periph_rst2_q(periph_rst2_q),
    .system_clock_sel_q(system_clock_sel_q), .main_osc_enable_q(main_osc_enable_q),
    .regulator_voltage_adjust_q(regulator_voltage_adjust_q));
